// ---- hdl/pwt_unit.sv ----
// Purpose: virtual to physical translation with table walk and buffer
// Assumes: memory answers each one-cycle load with one memRespValid pulse
// Notes:   linear table load first; physical walk only in privileged code
`timescale 1ns/1ps
module pwt_unit
  import pwt_pkg::*;
#(
  parameter int ENTRIES  = TB_ENTRIES,
  parameter bit HAS_TAGS = 1'b0
)(
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               nrst,
  // configuration
  input  wire logic [FRAME_W-1:0] tableRootFrame,
  input  wire logic [63:0]        linearTableBase,
  input  wire logic [TAG_W-1:0]   spaceTag,
  input  wire logic [1:0]         curMode,
  input  wire logic               privCode,
  // invalidation
  input  wire logic               invSingle,
  input  wire logic [63:0]        invSingleVa,
  input  wire logic               invAllReq,
  input  wire logic               invNonGlobal,
  input  wire logic               ctxSwap,
  // translation request and answer
  input  wire logic               reqValid,
  input  wire logic [63:0]        reqVa,
  input  wire pwt_kind_t          reqKind,
  output logic                    reqReady,
  output logic                    respValid,
  output logic [63:0]             respPa,
  output pwt_fault_t              respFault,
  // probe
  input  wire logic               probeValid,
  input  wire logic [63:0]        probeVa,
  output logic                    probeDone,
  output logic                    probeHit,
  // page table loads
  output logic                    memReqValid,
  output logic                    memVirt,
  output logic [63:0]             memAddr,
  input  wire logic               memRespValid,
  input  wire logic [63:0]        memData,
  input  wire logic               memMiss
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_LOOK, ST_PROBE, ST_VIRT, ST_WALK, ST_FIN
  } pwt_state_t;

  pwt_state_t  state_r;
  logic [63:0] va_r;
  pwt_kind_t   kind_r;
  logic [1:0]  mode_r;
  logic [63:0] pte_r;
  logic        fromMem_r;
  pwt_fault_t  force_r;
  logic [1:0]  lvl_r;
  logic        reqReady_r;
  logic        respValid_r;
  logic [63:0] respPa_r;
  pwt_fault_t  respFault_r;
  logic        probeDone_r;
  logic        probeHit_r;
  logic        memReqValid_r;
  logic        memVirt_r;
  logic [63:0] memAddr_r;
  pwt_fault_t  protFault;

  pwt_tb_if tb ();
  pwt_tlb #(.ENTRIES(ENTRIES), .HAS_TAGS(HAS_TAGS)) u_tlb (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .tb      (tb.store)
  );
  // only the third-level entry's code goes through protection; upper ones are checked for the valid and kernel read bits only
  pwt_prot u_prot (
    .ctl   (pte_r[PTE_CTL_W-1:0]),
    .mode  (mode_r),
    .kind  (kind_r),
    .fault (protFault)
  );

  function automatic logic [63:0] entryAddr(input logic [FRAME_W-1:0] fr,
                                            input logic [LVL_BITS-1:0] ix);
    entryAddr = (64'(fr) << PG_BITS) + (64'(ix) << ENT_SHIFT);
  endfunction : entryAddr

  // decode
  wire             sextBad   = reqVa[63:VA_SIZE] != {(64-VA_SIZE){reqVa[VA_SIZE-1]}};
  wire [63:0]      vptShl    = va_r << VPT_SHL;
  wire [63:0]      vptIdx    = vptShl >> VPT_SHR;
  // base trusted as written; a bad base just yields a bad load address
  wire [63:0]      vptAddr   = linearTableBase | vptIdx;
  wire [63:0]      rootAddr  = entryAddr(tableRootFrame, va_r[L1_LO +: LVL_BITS]);
  wire [LVL_BITS-1:0] nextIdx = (lvl_r == 2'd1) ? va_r[L2_LO +: LVL_BITS]
                                                 : va_r[L3_LO +: LVL_BITS];
  wire [63:0]      nextAddr  = entryAddr(memData[PTE_FRM_LO +: FRAME_W], nextIdx);
  wire             upperBad  = !memData[PTE_V];
  wire pwt_fault_t upperFlt  = memData[PTE_KREAD] ? FLT_INVALID : FLT_PROT;
  wire pwt_fault_t finFault  = (force_r != FLT_NONE) ? force_r : protFault;
  wire             acceptReq = state_r == ST_IDLE && reqValid;
  wire             acceptPrb = state_r == ST_IDLE && !reqValid && probeValid;

  // buffer hookup
  assign tb.lkVa     = (state_r == ST_IDLE) ? (reqValid ? reqVa : probeVa) : va_r;
  assign tb.lkTag    = spaceTag;
  // frame is only trusted when the valid bit is set, so only then is it cached
  assign tb.fillEn   = state_r == ST_FIN && fromMem_r && pte_r[PTE_V] &&
                       force_r == FLT_NONE;
  assign tb.fillVa   = va_r;
  assign tb.fillTag  = spaceTag;
  assign tb.fillData = '{frame: pte_r[PTE_FRM_LO +: FRAME_W],
                         ctl: pte_r[PTE_CTL_W-1:0]};
  assign tb.invOne   = invSingle;
  assign tb.invVa    = invSingleVa;
  assign tb.invAll   = invAllReq;
  assign tb.invLocal = invNonGlobal || (ctxSwap && !HAS_TAGS);

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_r       <= ST_IDLE;
      va_r          <= '0;
      kind_r        <= KIND_READ;
      mode_r        <= '0;
      pte_r         <= PTE_RST;
      fromMem_r     <= 1'b0;
      force_r       <= FLT_NONE;
      lvl_r         <= '0;
      reqReady_r    <= 1'b0;
      respValid_r   <= 1'b0;
      respPa_r      <= '0;
      respFault_r   <= FLT_NONE;
      probeDone_r   <= 1'b0;
      probeHit_r    <= 1'b0;
      memReqValid_r <= 1'b0;
      memVirt_r     <= 1'b0;
      memAddr_r     <= '0;
    end else begin
      respValid_r   <= 1'b0;
      probeDone_r   <= 1'b0;
      memReqValid_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          reqReady_r <= !reqValid && !probeValid;
          if (acceptReq) begin
            va_r      <= reqVa;
            kind_r    <= reqKind;
            mode_r    <= curMode;
            fromMem_r <= 1'b0;
            pte_r     <= PTE_RST;
            force_r   <= sextBad ? FLT_PROT : FLT_NONE;
            state_r   <= sextBad ? ST_FIN : ST_LOOK;
          end else if (acceptPrb) begin
            state_r <= ST_PROBE;
          end
        end
        ST_PROBE: begin
          probeDone_r <= 1'b1;
          probeHit_r  <= tb.hit;
          reqReady_r  <= 1'b1;
          state_r     <= ST_IDLE;
        end
        ST_LOOK: begin
          if (tb.hit) begin
            pte_r   <= {tb.hitData.frame, 16'h0000, tb.hitData.ctl};
            state_r <= ST_FIN;
          end else begin
            memReqValid_r <= 1'b1;
            memVirt_r     <= 1'b1;
            memAddr_r     <= vptAddr;
            state_r       <= ST_VIRT;
          end
        end
        ST_VIRT: begin
          if (memRespValid && !memMiss) begin
            pte_r     <= memData;
            fromMem_r <= 1'b1;
            state_r   <= ST_FIN;
          end else if (memRespValid && privCode) begin
            memReqValid_r <= 1'b1;
            memVirt_r     <= 1'b0;
            memAddr_r     <= rootAddr;
            lvl_r         <= 2'd1;
            state_r       <= ST_WALK;
          end else if (memRespValid) begin
            force_r <= FLT_INVALID;
            state_r <= ST_FIN;
          end
        end
        ST_WALK: begin
          if (memRespValid && lvl_r == 2'd3) begin
            pte_r     <= memData;
            fromMem_r <= 1'b1;
            state_r   <= ST_FIN;
          end else if (memRespValid && upperBad) begin
            force_r <= upperFlt;
            state_r <= ST_FIN;
          end else if (memRespValid) begin
            memReqValid_r <= 1'b1;
            memAddr_r     <= nextAddr;
            lvl_r         <= lvl_r + 2'd1;
          end
        end
        ST_FIN: begin
          respValid_r <= 1'b1;
          respPa_r    <= 64'({pte_r[PTE_FRM_LO +: FRAME_W], va_r[PG_BITS-1:0]});
          respFault_r <= finFault;
          reqReady_r  <= 1'b1;
          state_r     <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  assign reqReady    = reqReady_r;
  assign respValid   = respValid_r;
  assign respPa      = respPa_r;
  assign respFault   = respFault_r;
  assign probeDone   = probeDone_r;
  assign probeHit    = probeHit_r;
  assign memReqValid = memReqValid_r;
  assign memVirt     = memVirt_r;
  assign memAddr     = memAddr_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_virt_miss;
    state_r == ST_VIRT && memRespValid && memMiss && privCode;
  endsequence
  sequence s_root_load;
    memReqValid && !memVirt && lvl_r == 2'd1;
  endsequence
  property p_root_load;
    s_virt_miss |=> s_root_load ##0 memAddr == (64'(tableRootFrame) << PG_BITS) +
      (64'(va_r[L1_LO +: LVL_BITS]) << ENT_SHIFT);
  endproperty
  a_root_load: assert property (p_root_load) else $error("bad first-level load");
  property p_vpt_load;
    state_r == ST_LOOK && !tb.hit |=> memReqValid && memVirt &&
      memAddr == (linearTableBase | ((va_r << VPT_SHL) >> VPT_SHR));
  endproperty
  a_vpt_load: assert property (p_vpt_load) else $error("bad linear table load");
  property p_pa_join;
    respValid && respFault == FLT_NONE |->
      respPa[PG_BITS-1:0] == va_r[PG_BITS-1:0] &&
      respPa[63:PG_BITS] == 51'(pte_r[63:PTE_FRM_LO]);
  endproperty
  a_pa_join: assert property (p_pa_join) else $error("bad physical address");
  property p_upper_bad;
    state_r == ST_WALK && memRespValid && lvl_r != 2'd3 && !memData[PTE_V] |=>
      ##1 respValid && respFault == ($past(memData[PTE_KREAD], 2) ? FLT_INVALID : FLT_PROT);
  endproperty
  a_upper_bad: assert property (p_upper_bad) else $error("upper entry fault wrong");
  property p_sext;
    acceptReq && sextBad |=> ##1 respValid && respFault == FLT_PROT && !memReqValid;
  endproperty
  a_sext: assert property (p_sext) else $error("non-canonical address passed");
  // checks what the buffer hands back, not just the fill gate
  property p_no_bad_fill;
    state_r == ST_LOOK && tb.hit |-> tb.hitData.ctl[PTE_V];
  endproperty
  a_no_bad_fill: assert property (p_no_bad_fill) else $error("invalid entry cached");
  property p_prio;
    state_r == ST_FIN && force_r == FLT_NONE && protFault == FLT_PROT |=>
      respValid && respFault == FLT_PROT;
  endproperty
  a_prio: assert property (p_prio) else $error("protection fault lost");
  property p_probe;
    acceptPrb |=> ##1 probeDone && probeHit == $past(tb.hit);
  endproperty
  a_probe: assert property (p_probe) else $error("probe answer wrong");
endmodule : pwt_unit

// ---- hdl/pwt_pkg.sv ----
// Purpose: shared constants and types for the page walk translation unit
// Assumes: 8 KB pages, 43 implemented virtual address bits, 64-bit entries
// Notes:   entry bit positions and shift amounts live here only
package pwt_pkg;
  localparam int PG_BITS    = 13;
  localparam int VA_SIZE    = 43;
  localparam int LVL_BITS   = 10;
  localparam int FRAME_W    = 32;
  localparam int TAG_W      = 8;
  localparam int VPN_W      = VA_SIZE - PG_BITS;
  localparam int L1_LO      = PG_BITS + 2 * LVL_BITS;
  localparam int L2_LO      = PG_BITS + LVL_BITS;
  localparam int L3_LO      = PG_BITS;
  localparam int ENT_SHIFT  = 3;
  // entry fields
  localparam int PTE_V      = 0;
  localparam int PTE_FLT_RD = 1;
  localparam int PTE_FLT_WR = 2;
  localparam int PTE_FLT_EX = 3;
  localparam int PTE_GLOBAL = 4;
  localparam int PTE_KREAD  = 8;
  localparam int PTE_RE_LO  = 8;
  localparam int PTE_WE_LO  = 12;
  localparam int PTE_CTL_W  = 16;
  localparam int PTE_FRM_LO = 32;
  // linear table index shifts
  localparam int VPT_SHL    = 64 - (4 * PG_BITS - 9);
  localparam int VPT_SHR    = VPT_SHL + PG_BITS - 3;
  localparam int TB_ENTRIES = 8;
  localparam logic [63:0] PTE_RST = 64'h0;

  typedef enum logic [1:0] {KIND_READ, KIND_WRITE, KIND_EXEC} pwt_kind_t;
  typedef enum logic [2:0] {
    FLT_NONE, FLT_PROT, FLT_INVALID, FLT_READ, FLT_WRITE, FLT_EXEC
  } pwt_fault_t;
  typedef struct packed {
    logic [FRAME_W-1:0]   frame;
    logic [PTE_CTL_W-1:0] ctl;
  } pwt_xlat_t;
endpackage : pwt_pkg

// ---- hdl/pwt_tb_if.sv ----
// Purpose: carrier between the walker and its translation buffer
// Assumes: lookup answer is registered, one cycle after the address
// Notes:   fill and invalidate strobes are single-cycle
`timescale 1ns/1ps
interface pwt_tb_if;
  import pwt_pkg::*;
  logic [63:0]      lkVa;
  logic [TAG_W-1:0] lkTag;
  logic             hit;
  pwt_xlat_t        hitData;
  logic             fillEn;
  logic [63:0]      fillVa;
  logic [TAG_W-1:0] fillTag;
  pwt_xlat_t        fillData;
  logic             invOne;
  logic [63:0]      invVa;
  logic             invAll;
  logic             invLocal;
  modport ctl (output lkVa, lkTag, fillEn, fillVa, fillTag, fillData,
               output invOne, invVa, invAll, invLocal, input hit, hitData);
  modport store (input lkVa, lkTag, fillEn, fillVa, fillTag, fillData,
                 input invOne, invVa, invAll, invLocal, output hit, hitData);
endinterface : pwt_tb_if

// ---- hdl/pwt_prot.sv ----
// Purpose: third-level protection and fault priority
// Assumes: mode 0 kernel .. 3 user; fetch counts as a read
// Notes:   purely combinational
`timescale 1ns/1ps
module pwt_prot
  import pwt_pkg::*;
(
  // entry and access
  input  wire logic [PTE_CTL_W-1:0] ctl,
  input  wire logic [1:0]           mode,
  input  wire pwt_kind_t            kind,
  // result
  output pwt_fault_t                fault
);
  wire [3:0] readEn  = ctl[PTE_RE_LO +: 4];
  wire [3:0] writeEn = ctl[PTE_WE_LO +: 4];
  wire       isWrite = (kind == KIND_WRITE);
  wire       noAcc   = isWrite ? !writeEn[mode] : !readEn[mode];
  wire       notVal  = !ctl[PTE_V];
  wire       rdFlt   = (kind == KIND_READ) && ctl[PTE_FLT_RD];
  wire       wrFlt   = isWrite && ctl[PTE_FLT_WR];
  wire       exFlt   = (kind == KIND_EXEC) && ctl[PTE_FLT_EX];
  // access violation reported first, then an invalid entry, then the read, write and execute fault bits
  assign fault = noAcc  ? FLT_PROT    :
                 notVal ? FLT_INVALID :
                 rdFlt  ? FLT_READ    :
                 wrFlt  ? FLT_WRITE   :
                 exFlt  ? FLT_EXEC    : FLT_NONE;
endmodule : pwt_prot

// ---- hdl/pwt_tlb.sv ----
// Purpose: small fully associative translation buffer
// Assumes: only valid entries are ever filled
// Notes:   lookup result registered; round-robin replacement
`timescale 1ns/1ps
module pwt_tlb
  import pwt_pkg::*;
#(
  parameter int ENTRIES  = TB_ENTRIES,
  parameter bit HAS_TAGS = 1'b0
)(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic nrst,
  // walker side
  pwt_tb_if.store   tb
);
  logic [ENTRIES-1:0] valid_r;
  logic [VPN_W-1:0]   vpn_r   [ENTRIES];
  logic [TAG_W-1:0]   tag_r   [ENTRIES];
  pwt_xlat_t          data_r  [ENTRIES];
  logic [ENTRIES-1:0] match;
  logic [ENTRIES-1:0] dropOne;
  logic [ENTRIES-1:0] isGlobal;
  pwt_xlat_t          orData  [ENTRIES+1];
  logic [$clog2(ENTRIES)-1:0] victim_r;
  logic               hit_r;
  pwt_xlat_t          hitData_r;

  assign orData[0] = '0;
  for (genvar i = 0; i < ENTRIES; i++) begin : g_ent
    // tags are local to this processor; out-of-range tags are undefined
    assign match[i] = valid_r[i] && vpn_r[i] == tb.lkVa[PG_BITS +: VPN_W] &&
      (!HAS_TAGS || data_r[i].ctl[PTE_GLOBAL] || tag_r[i] == tb.lkTag);
    assign dropOne[i] = tb.invOne && vpn_r[i] == tb.invVa[PG_BITS +: VPN_W];
    assign orData[i+1] = orData[i] | (match[i] ? data_r[i] : '0);
    assign isGlobal[i] = data_r[i].ctl[PTE_GLOBAL];
    always_ff @(posedge sys_clk) begin
      if (!nrst) begin
        valid_r[i] <= 1'b0;
      end else if (tb.fillEn && victim_r == i) begin
        valid_r[i] <= 1'b1;
      end else if (tb.invAll || dropOne[i] ||
                   (tb.invLocal && !data_r[i].ctl[PTE_GLOBAL])) begin
        valid_r[i] <= 1'b0;
      end
    end
    always_ff @(posedge sys_clk) begin
      if (tb.fillEn && victim_r == i) begin
        vpn_r[i]  <= tb.fillVa[PG_BITS +: VPN_W];
        tag_r[i]  <= tb.fillTag;
        data_r[i] <= tb.fillData;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      victim_r  <= '0;
      hit_r     <= 1'b0;
      hitData_r <= '0;
    end else begin
      if (tb.fillEn) victim_r <= victim_r + 1'b1;
      hit_r     <= |match;
      hitData_r <= orData[ENTRIES];
    end
  end
  assign tb.hit     = hit_r;
  assign tb.hitData = hitData_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  property p_inv_all;
    tb.invAll && !tb.fillEn |=> valid_r == '0;
  endproperty
  a_inv_all: assert property (p_inv_all) else $error("flush left an entry");
  // globals must survive, every other entry must go
  property p_inv_local;
    tb.invLocal && !tb.fillEn && !tb.invAll && !tb.invOne |=>
      valid_r == ($past(valid_r) & isGlobal);
  endproperty
  a_inv_local: assert property (p_inv_local) else $error("local entry survived");
endmodule : pwt_tlb

// ---- verification/pwt_mem_model.sv ----
// Purpose: memory holding page tables, answering the unit's one-cycle loads
// Assumes: one answer per load, lag + 1 cycles after the load is seen
// Notes:   data line is inverted each cycle outside answers so a stale value never holds two cycles running
`timescale 1ns/1ps
module pwt_mem_model (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // load side
  input  wire logic        memReqValid,
  input  wire logic        memVirt,
  input  wire logic [63:0] memAddr,
  output logic             memRespValid,
  output logic [63:0]      memData,
  output logic             memMiss,
  // bench knobs
  input  wire logic [3:0]  lag,
  input  wire logic        virtMiss
);
  // unwritten places read as zero: invalid entry, kernel read clear
  logic [63:0] mem [logic [63:0]];
  logic [63:0] addrQ;
  logic        virtQ, busy;
  logic [3:0]  cnt;

  always @(posedge sys_clk) begin
    memRespValid <= 1'b0;
    memMiss      <= 1'b0;
    memData      <= ~memData;
    if (!nrst) begin
      busy    <= 1'b0;
      memData <= 64'h0;
    end else if (memReqValid) begin
      busy  <= 1'b1;
      cnt   <= lag;
      addrQ <= memAddr;
      virtQ <= memVirt;
    end else if (busy && cnt == 4'h0) begin
      busy         <= 1'b0;
      memRespValid <= 1'b1;
      memMiss      <= virtQ & virtMiss;
      memData      <= mem.exists(addrQ) ? mem[addrQ] : 64'h0;
    end else if (busy) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule : pwt_mem_model

// ---- verification/pwt_unit_tb.sv ----
// Purpose: self-checking bench for the page walk translation unit
// Assumes: bench plays the pipeline; model plays table memory
// Notes:   every load address is logged; t_phys compares each with the walk, t_upper and t_faults count them
`timescale 1ns/1ps
module pwt_unit_tb;
  import pwt_pkg::*;
  localparam logic [63:0] BASE = 64'h0000_0200_0000_0000;
  localparam logic [63:0] ROOT = 64'h0000_0000_0000_0010;
  logic            sys_clk, nrst, privCode, invSingle, invAllReq, invNonGlobal;
  logic            ctxSwap, reqValid, reqReady, respValid, probeValid, probeDone;
  logic            probeHit, memReqValid, memVirt, memRespValid, memMiss, virtMiss;
  logic [1:0]      curMode;
  logic [3:0]      lag;
  logic [63:0]     invSingleVa, reqVa, respPa, probeVa, memAddr, memData, pa;
  pwt_kind_t       reqKind;
  pwt_fault_t      respFault, flt;
  int              errors, samples_checked, lat;
  logic [63:0]     ldAddr [$];
  logic            ldVirt [$];

  pwt_unit u_pwt_unit (.sys_clk(sys_clk), .nrst(nrst), .tableRootFrame(ROOT[31:0]),
    .linearTableBase(BASE), .spaceTag(8'h00), .curMode(curMode), .privCode(privCode),
    .invSingle(invSingle), .invSingleVa(invSingleVa), .invAllReq(invAllReq),
    .invNonGlobal(invNonGlobal), .ctxSwap(ctxSwap), .reqValid(reqValid), .reqVa(reqVa),
    .reqKind(reqKind), .reqReady(reqReady), .respValid(respValid), .respPa(respPa),
    .respFault(respFault), .probeValid(probeValid), .probeVa(probeVa),
    .probeDone(probeDone), .probeHit(probeHit), .memReqValid(memReqValid),
    .memVirt(memVirt), .memAddr(memAddr), .memRespValid(memRespValid),
    .memData(memData), .memMiss(memMiss));
  pwt_mem_model u_pwt_mem_model (.sys_clk(sys_clk), .nrst(nrst), .memReqValid(memReqValid),
    .memVirt(memVirt), .memAddr(memAddr), .memRespValid(memRespValid), .memData(memData),
    .memMiss(memMiss), .lag(lag), .virtMiss(virtMiss));

  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (nrst && memReqValid) begin
      ldAddr.push_back(memAddr);
      ldVirt.push_back(memVirt);
    end
  end

  function automatic logic [63:0] lin(input logic [63:0] va);
    lin = ((va << (64 - (4 * PG_BITS - 9))) >> (64 - (4 * PG_BITS - 9) + PG_BITS - 3)) | BASE;
  endfunction : lin

  function automatic logic [63:0] ent(input logic [63:0] frm, input logic [9:0] ix);
    ent = (frm << 13) + 64'(ix) * 64'h8;
  endfunction : ent

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic idle_wait();
    int n;
    n = 0;
    while (reqReady !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    chk(64'(n < 100), 64'h1);
    @(posedge sys_clk);
  endtask : idle_wait

  task automatic xlate(input logic [63:0] va, input pwt_kind_t k, input logic [1:0] m);
    idle_wait();
    ldAddr.delete();
    ldVirt.delete();
    reqValid <= 1'b1;
    reqVa    <= va;
    reqKind  <= k;
    curMode  <= m;
    @(posedge sys_clk);
    reqValid <= 1'b0;
    lat = 0;
    do begin
      @(negedge sys_clk);
      lat++;
    end while (respValid !== 1'b1 && lat < 300);
    pa  = respPa;
    flt = respFault;
    chk(64'(lat < 300), 64'h1);
  endtask : xlate

  task automatic probe(input logic [63:0] va, input logic exp);
    int n;
    idle_wait();
    probeValid <= 1'b1;
    probeVa    <= va;
    @(posedge sys_clk);
    probeValid <= 1'b0;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (probeDone !== 1'b1 && n < 100);
    chk(64'(probeDone), 64'h1);
    chk(64'(probeHit), 64'(exp));
  endtask : probe

  task automatic pulse(input int w, input logic [63:0] va);
    @(posedge sys_clk);
    invSingleVa <= va;
    case (w)
      0: invAllReq <= 1'b1;
      1: invNonGlobal <= 1'b1;
      2: ctxSwap <= 1'b1;
      default: invSingle <= 1'b1;
    endcase
    @(posedge sys_clk);
    {invAllReq, invNonGlobal, ctxSwap, invSingle} <= 4'h0;
  endtask : pulse

  // linear load misses, slow memory, so the three physical loads run
  task automatic t_phys();
    logic [63:0] va, ex [4];
    va = 64'h0000_0123_4567_83A8;
    ex = '{lin(va), ent(ROOT, va[42:33]), ent(64'h20, va[32:23]), ent(64'h30, va[22:13])};
    u_pwt_mem_model.mem[ex[1]] = 64'h0000_0020_0000_0001;
    u_pwt_mem_model.mem[ex[2]] = 64'h0000_0030_0000_0001;
    u_pwt_mem_model.mem[ex[3]] = 64'h0000_0044_0000_FF01;
    virtMiss <= 1'b1;
    lag      <= 4'h3;
    xlate(va, KIND_READ, 2'h3);
    chk(64'(flt), 64'(FLT_NONE));
    chk(pa, {19'h0, 32'h44, va[12:0]});
    chk(64'(ldAddr.size()), 64'h4);
    for (int i = 0; i < 4; i++) begin
      chk(ldAddr[i], ex[i]);
      chk(64'(ldVirt[i]), 64'(i == 0));
    end
    xlate(va, KIND_READ, 2'h3);
    chk(64'(lat), 64'h3);
    chk(64'(ldAddr.size()), 64'h0);
    chk(pa, {19'h0, 32'h44, va[12:0]});
  endtask : t_phys

  // invalid first-level entry, then a non-canonical address
  task automatic t_upper();
    for (int i = 0; i < 2; i++) begin
      u_pwt_mem_model.mem[ent(ROOT, 10'(i + 1))] = (i == 1) ? 64'h100 : 64'h0;
      xlate(64'(i + 1) << 33, KIND_READ, 2'h0);
      chk(64'(flt), 64'((i == 1) ? FLT_INVALID : FLT_PROT));
      chk(64'(ldAddr.size()), 64'h2);
    end
    // without privileged code a linear miss faults instead of walking
    @(posedge sys_clk);
    privCode <= 1'b0;
    xlate(64'h3 << 33, KIND_READ, 2'h1);
    chk(64'(flt), 64'(FLT_INVALID));
    chk(64'(ldAddr.size()), 64'h1);
    @(posedge sys_clk);
    privCode <= 1'b1;
    xlate(64'h0000_0400_0000_0000, KIND_READ, 2'h0);
    chk(64'(flt), 64'(FLT_PROT));
    chk(64'(ldAddr.size()), 64'h0);
  endtask : t_upper

  // third-level codes through the linear load, prompt memory
  task automatic t_faults();
    logic [15:0] c [9] = '{16'hFF00, 16'hF701, 16'hFF03, 16'hFF05, 16'hFF09,
                           16'h0000, 16'hFF02, 16'h1101, 16'h1101};
    logic [1:0]  m [9] = '{0, 3, 0, 0, 0, 0, 0, 0, 2};
    pwt_kind_t   k [9] = '{KIND_READ, KIND_READ, KIND_READ, KIND_WRITE, KIND_EXEC,
                           KIND_READ, KIND_READ, KIND_WRITE, KIND_WRITE};
    pwt_fault_t  e [9] = '{FLT_INVALID, FLT_PROT, FLT_READ, FLT_WRITE, FLT_EXEC,
                           FLT_PROT, FLT_INVALID, FLT_NONE, FLT_PROT};
    logic [63:0] va;
    virtMiss <= 1'b0;
    lag      <= 4'h0;
    for (int i = 0; i < 9; i++) begin
      va = (64'(i + 8) << 13) | 64'h1A8;
      u_pwt_mem_model.mem[lin(va)] = {32'(i + 80), 16'h0, c[i]};
      xlate(va, k[i], m[i]);
      chk(64'(flt), 64'(e[i]));
      if (e[i] == FLT_NONE) chk(pa, {19'h0, 32'(i + 80), va[12:0]});
    end
    xlate(64'h1_01A8, KIND_READ, 2'h0);
    chk(64'(ldAddr.size()), 64'h1);
  endtask : t_faults

  // global and non-global fills against non-global and context-swap invalidates, the global fill alone against flush and single
  task automatic t_inval();
    logic [63:0] vg, vn;
    vg = 64'h0100_0000;
    vn = 64'h0100_2000;
    u_pwt_mem_model.mem[lin(vg)] = 64'h0000_0061_0000_FF11;
    u_pwt_mem_model.mem[lin(vn)] = 64'h0000_0062_0000_FF01;
    xlate(vg, KIND_READ, 2'h0);
    xlate(vn, KIND_READ, 2'h0);
    probe(vg, 1'b1);
    probe(vn, 1'b1);
    pulse(1, 64'h0);
    probe(vg, 1'b1);
    probe(vn, 1'b0);
    xlate(vn, KIND_READ, 2'h0);
    pulse(2, 64'h0);
    probe(vg, 1'b1);
    probe(vn, 1'b0);
    pulse(0, 64'h0);
    probe(vg, 1'b0);
    xlate(vg, KIND_READ, 2'h0);
    pulse(3, vg | 64'h40);
    probe(vg, 1'b0);
  endtask : t_inval

  task automatic print_verdict();
    $display("checks=%0d errors=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  initial begin
    {sys_clk, nrst, invSingle, invAllReq, invNonGlobal, ctxSwap, reqValid} = 7'h0;
    {probeValid, virtMiss, curMode, lag, privCode} = 9'h1;
    {invSingleVa, reqVa, probeVa} = '0;
    reqKind = KIND_READ;
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    t_phys();
    t_upper();
    t_faults();
    t_inval();
    print_verdict();
  end

  // whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    print_verdict();
  end
endmodule : pwt_unit_tb
